// ### verilog/prot_fault_pkg.sv
// Constants for the protection fault reporting register bank.
// Assumes an 8-bit register access port driven by the I2C front end.
package prot_fault_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_WARNING_FLAGS  = 8'h73;
	localparam logic [7:0] ADDR_FAULT_MASK     = 8'h74;
	localparam logic [7:0] ADDR_LATCH_MASK     = 8'h75;
	localparam logic [7:0] ADDR_MISC_CTRL      = 8'h76;
	localparam logic [7:0] ADDR_CURRENT_LIMIT  = 8'h77;
	localparam logic [7:0] ADDR_FAULT_CLEAR    = 8'h78;

	// Values after reset
	localparam logic [7:0] RESET_WARNING_FLAGS = 8'h00;
	localparam logic [7:0] RESET_FAULT_MASK    = 8'h00;
	localparam logic [7:0] RESET_LATCH_MASK    = 8'hf8;
	localparam logic [7:0] RESET_MISC_CTRL     = 8'h00;
	localparam logic [7:0] RESET_CURRENT_LIMIT = 8'h00;
	localparam logic [7:0] RESET_FAULT_CLEAR   = 8'h00;

	// Writable bits of each register
	localparam logic [7:0] WMASK_FAULT_MASK    = 8'hf7;
	localparam logic [7:0] WMASK_LATCH_MASK    = 8'hff;
	localparam logic [7:0] WMASK_MISC_CTRL     = 8'hff;
	localparam logic [7:0] WMASK_CURRENT_LIMIT = 8'hff;
	localparam logic [7:0] WMASK_FAULT_CLEAR   = 8'h7f;

	// Fault report mask fields
	localparam int MASK_THERMAL_SHUTDOWN   = 7;
	localparam int MASK_LOGIC_SUPPLY_UNDER = 6;
	localparam int MASK_LOGIC_SUPPLY_OVER  = 5;
	localparam int MASK_CLOCK_ERROR        = 4;
	localparam int MASK_POWER_SUPPLY_VOLT  = 2;
	localparam int MASK_OUTPUT_OFFSET      = 1;
	localparam int MASK_OVERCURRENT        = 0;

	// Latch and mask control fields
	localparam int CYCLE_LIMIT_FAULT_LATCH_EN = 7;
	localparam int CYCLE_LIMIT_WARN_LATCH_EN  = 6;
	localparam int CLOCK_ERROR_LATCH_EN       = 5;
	localparam int THERMAL_SHUTDOWN_LATCH_EN  = 4;
	localparam int OVERTEMP_WARN_LATCH_EN     = 3;
	localparam int MASK_OVERTEMP_WARN         = 2;
	localparam int MASK_CYCLE_LIMIT_WARN      = 1;
	localparam int MASK_CYCLE_LIMIT_FAULT     = 0;

	// Misc, current limit and clear fields
	localparam int CLOCK_DETECT_HOLD       = 7;
	localparam int THERMAL_AUTO_RECOVER_EN = 4;
	localparam int CYCLE_LIMIT_EN          = 2;
	localparam int CYCLE_LIMIT_WARN_EN     = 1;
	localparam int CYCLE_LIMIT_FAULT_EN    = 0;
	localparam int ANALOG_FAULT_CLEAR      = 7;

	// Warning bank index equals the warning register bit
	localparam int WARN_FLAG_COUNT           = 6;
	localparam int OVERTEMP_WARN_LEVEL_ONE   = 0;
	localparam int OVERTEMP_WARN_LEVEL_TWO   = 1;
	localparam int OVERTEMP_WARN_LEVEL_THREE = 2;
	localparam int OVERTEMP_WARN_LEVEL_FOUR  = 3;
	localparam int RIGHT_CYCLE_LIMIT_WARN    = 4;
	localparam int LEFT_CYCLE_LIMIT_WARN     = 5;

	// Fault bank indices
	localparam int FAULT_FLAG_COUNT   = 11;
	localparam int FLT_OC_LEFT        = 0;
	localparam int FLT_OC_RIGHT       = 1;
	localparam int FLT_DC_LEFT        = 2;
	localparam int FLT_DC_RIGHT       = 3;
	localparam int FLT_PWR_UNDER      = 4;
	localparam int FLT_PWR_OVER       = 5;
	localparam int FLT_CLOCK          = 6;
	localparam int FLT_CYCLE_LEFT     = 7;
	localparam int FLT_CYCLE_RIGHT    = 8;
	localparam int FLT_THERMAL        = 9;
	localparam int FLT_CLOCK_DETECT   = 10;

endpackage : prot_fault_pkg

// ### verilog/flag_bank_if.sv
// Interface joining the register bank to one sticky flag bank.
// Assumes both ends share ref_clk; the clear is a one-cycle pulse.
`timescale 1ns/1ps
interface flag_bank_if #(
	parameter int W = 8
);
	logic [W-1:0] cond;
	logic [W-1:0] latchEn;
	logic         clear;
	logic [W-1:0] flags;

	modport ctrl (output cond, output latchEn, output clear, input flags);
	modport bank (input cond, input latchEn, input clear, output flags);
endinterface : flag_bank_if

// ### verilog/flag_latch_bank.sv
// Bank of status flags, each either sticky or following its condition.
// Assumes conditions are synchronous to ref_clk.
`timescale 1ns/1ps
module flag_latch_bank (
	input wire logic    ref_clk,
	input wire logic    nrst,
	flag_bank_if.bank   fb
);

	// A live condition always sets its flag, so a clear never loses an event
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fb.flags <= '0;
		end else if (fb.clear) begin
			fb.flags <= fb.cond;
		end else begin
			fb.flags <= fb.cond | (fb.flags & fb.latchEn); // [R18]
		end
	end

endmodule : flag_latch_bank

// ### verilog/fault_report_unit.sv
// Combines status flags and masks into the fault pin and output disable.
// Assumes flag vectors laid out by the package indices.
`timescale 1ns/1ps
module fault_report_unit (
	input wire logic                                   ref_clk,
	input wire logic                                   nrst,
	input wire logic [prot_fault_pkg::FAULT_FLAG_COUNT-1:0] faultFlags,
	input wire logic [prot_fault_pkg::WARN_FLAG_COUNT-1:0]  warnFlags,
	input wire logic [7:0]                             faultMaskReg,
	input wire logic [7:0]                             latchMaskReg,
	input wire logic                                   thermalAutoRecoverEn,
	input wire logic                                   thermalShutdownCond,
	input wire logic                                   powerSupplyUnderCond,
	input wire logic                                   powerSupplyOverCond,
	input wire logic                                   clockErrorCond,
	input wire logic                                   logicSupplyUnderCond,
	input wire logic                                   logicSupplyOverCond,
	output logic                                       faultPinN,
	output logic                                       outputHiZ
);

	logic report;
	logic hiZ;
	logic otwAny;
	logic cbcwAny;
	logic cbcfAny;

	assign otwAny  = |warnFlags[prot_fault_pkg::OVERTEMP_WARN_LEVEL_FOUR:0];
	assign cbcwAny = warnFlags[prot_fault_pkg::LEFT_CYCLE_LIMIT_WARN]
		| warnFlags[prot_fault_pkg::RIGHT_CYCLE_LIMIT_WARN];
	assign cbcfAny = faultFlags[prot_fault_pkg::FLT_CYCLE_LEFT]
		| faultFlags[prot_fault_pkg::FLT_CYCLE_RIGHT];

	// Masks gate only the pin; the flags themselves keep setting
	always_comb begin
		report = 1'b0;
		report |= faultFlags[prot_fault_pkg::FLT_THERMAL]
			& ~faultMaskReg[prot_fault_pkg::MASK_THERMAL_SHUTDOWN]; // [R5] [R19]
		report |= logicSupplyUnderCond & ~faultMaskReg[prot_fault_pkg::MASK_LOGIC_SUPPLY_UNDER]; // [R6]
		report |= logicSupplyOverCond & ~faultMaskReg[prot_fault_pkg::MASK_LOGIC_SUPPLY_OVER]; // [R6]
		report |= faultFlags[prot_fault_pkg::FLT_CLOCK]
			& ~faultMaskReg[prot_fault_pkg::MASK_CLOCK_ERROR]; // [R7]
		report |= (faultFlags[prot_fault_pkg::FLT_PWR_UNDER] | faultFlags[prot_fault_pkg::FLT_PWR_OVER])
			& ~faultMaskReg[prot_fault_pkg::MASK_POWER_SUPPLY_VOLT]; // [R8]
		report |= (faultFlags[prot_fault_pkg::FLT_DC_LEFT] | faultFlags[prot_fault_pkg::FLT_DC_RIGHT])
			& ~faultMaskReg[prot_fault_pkg::MASK_OUTPUT_OFFSET]; // [R9]
		report |= (faultFlags[prot_fault_pkg::FLT_OC_LEFT] | faultFlags[prot_fault_pkg::FLT_OC_RIGHT])
			& ~faultMaskReg[prot_fault_pkg::MASK_OVERCURRENT]; // [R9] [R17]
		report |= otwAny & ~latchMaskReg[prot_fault_pkg::MASK_OVERTEMP_WARN]; // [R12]
		report |= cbcwAny & ~latchMaskReg[prot_fault_pkg::MASK_CYCLE_LIMIT_WARN]; // [R12]
		report |= cbcfAny & ~latchMaskReg[prot_fault_pkg::MASK_CYCLE_LIMIT_FAULT]; // [R12]
	end

	// Supply and clock faults recover on their own, so the stage follows the live level
	always_comb begin
		hiZ = faultFlags[prot_fault_pkg::FLT_OC_LEFT] | faultFlags[prot_fault_pkg::FLT_OC_RIGHT]
			| faultFlags[prot_fault_pkg::FLT_DC_LEFT] | faultFlags[prot_fault_pkg::FLT_DC_RIGHT]
			| cbcfAny | powerSupplyUnderCond | powerSupplyOverCond | clockErrorCond; // [R17]
		hiZ |= thermalAutoRecoverEn ? thermalShutdownCond
			: faultFlags[prot_fault_pkg::FLT_THERMAL]; // [R14]
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			faultPinN <= 1'b1;
			outputHiZ <= 1'b0;
		end else begin
			faultPinN <= ~report; // [R17]
			outputHiZ <= hiZ; // [R17]
		end
	end

endmodule : fault_report_unit

// ### verilog/protection_fault_report_ctrl.sv
// Protection reporting registers: warnings, masks, latch enables, current limit.
// Assumes an I2C front end that presents one-cycle read and write strobes
// on ref_clk, and analog detectors whose levels are synchronous to ref_clk.
`timescale 1ns/1ps
//
// Contract
// [R1] Warning bits 5/4: left/right cycle-limit warnings
// [R2] Warning bits 0/1: overtemp levels one, two
// [R3] Warning bits 2/3: overtemp levels three, four
// [R4] Warning register resets zero, top bits zero
// [R5] Fault mask bit 7 hides thermal shutdown
// [R6] Mask bits 6/5 hide logic supply faults
// [R7] Mask bit 4 hides clock; bit 3 reserved
// [R8] Mask bit 2 hides power supply faults
// [R9] Mask bits 1/0 hide offset, overcurrent faults
// [R10] Latch bits 7/6/5: cycle fault, warning, clock
// [R11] Latch bits 4/3 thermal; reset value f8
// [R12] Bits 2/1/0 mask overtemp, cycle warn, fault
// [R13] Misc bit 7 holds clock detect status
// [R14] Misc bit 4 enables thermal auto recovery
// [R15] Current limit bits 2/1/0: enable, warn, fault
// [R16] Clear bit 7 write clears latched faults
// [R17] Fault sets flag, disables stage, drives pin; logic supply faults only drive the pin
// [R18] Latched flag sticks; unlatched follows condition
// [R19] Masks gate pin only, flags still set
module protection_fault_report_ctrl (
	input wire logic        ref_clk,
	input wire logic        nrst,
	// Register access port from the I2C front end
	input wire logic        regWrEn,
	input wire logic        regRdEn,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWrData,
	output logic [7:0]      regRdData,
	// Detector levels
	input wire logic        leftCycleLimitWarnCond,
	input wire logic        rightCycleLimitWarnCond,
	input wire logic [3:0]  overtempWarnCond,
	input wire logic        leftCycleLimitFaultCond,
	input wire logic        rightCycleLimitFaultCond,
	input wire logic        leftOvercurrentCond,
	input wire logic        rightOvercurrentCond,
	input wire logic        leftOutputOffsetCond,
	input wire logic        rightOutputOffsetCond,
	input wire logic        powerSupplyUnderCond,
	input wire logic        powerSupplyOverCond,
	input wire logic        logicSupplyUnderCond,
	input wire logic        logicSupplyOverCond,
	input wire logic        clockErrorCond,
	input wire logic        clockDetectCond,
	input wire logic        thermalShutdownCond,
	// Status and control toward the rest of the device
	output logic [10:0]     faultStatus,
	output logic            clockDetectStatus,
	output logic            cycleLimitEn,
	output logic            cycleLimitWarnEn,
	output logic            cycleLimitFaultEn,
	output logic            thermalAutoRecoverEn,
	output logic            analogFaultClear,
	output logic            faultPinN,
	output logic            outputHiZ
);

	logic [7:0] faultMaskReg;
	logic [7:0] latchMaskReg;
	logic [7:0] miscCtrlReg;
	logic [7:0] currentLimitReg;
	logic [7:0] faultClearReg;
	logic [7:0] warningFlagsReg;
	logic [7:0] regRdData_next;
	logic       clearPulseReg;

	flag_bank_if #(.W(prot_fault_pkg::WARN_FLAG_COUNT))  warnIf ();
	flag_bank_if #(.W(prot_fault_pkg::FAULT_FLAG_COUNT)) faultIf ();

	// Register writes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			faultMaskReg <= prot_fault_pkg::RESET_FAULT_MASK; // [R9]
		end else if (regWrEn && regAddr == prot_fault_pkg::ADDR_FAULT_MASK) begin
			faultMaskReg <= regWrData & prot_fault_pkg::WMASK_FAULT_MASK; // [R7]
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			latchMaskReg <= prot_fault_pkg::RESET_LATCH_MASK; // [R11]
		end else if (regWrEn && regAddr == prot_fault_pkg::ADDR_LATCH_MASK) begin
			latchMaskReg <= regWrData & prot_fault_pkg::WMASK_LATCH_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			miscCtrlReg <= prot_fault_pkg::RESET_MISC_CTRL; // [R14]
		end else if (regWrEn && regAddr == prot_fault_pkg::ADDR_MISC_CTRL) begin
			miscCtrlReg <= regWrData & prot_fault_pkg::WMASK_MISC_CTRL;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			currentLimitReg <= prot_fault_pkg::RESET_CURRENT_LIMIT; // [R15]
		end else if (regWrEn && regAddr == prot_fault_pkg::ADDR_CURRENT_LIMIT) begin
			currentLimitReg <= regWrData & prot_fault_pkg::WMASK_CURRENT_LIMIT;
		end
	end

	// The clear bit is never stored; only the reserved storage bits are
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			faultClearReg <= prot_fault_pkg::RESET_FAULT_CLEAR;
			clearPulseReg <= 1'b0;
		end else begin
			clearPulseReg <= regWrEn && regAddr == prot_fault_pkg::ADDR_FAULT_CLEAR
				&& regWrData[prot_fault_pkg::ANALOG_FAULT_CLEAR]; // [R16]
			if (regWrEn && regAddr == prot_fault_pkg::ADDR_FAULT_CLEAR) begin
				faultClearReg <= regWrData & prot_fault_pkg::WMASK_FAULT_CLEAR;
			end
		end
	end

	assign cycleLimitEn         = currentLimitReg[prot_fault_pkg::CYCLE_LIMIT_EN]; // [R15]
	assign cycleLimitWarnEn     = currentLimitReg[prot_fault_pkg::CYCLE_LIMIT_WARN_EN]; // [R15]
	assign cycleLimitFaultEn    = currentLimitReg[prot_fault_pkg::CYCLE_LIMIT_FAULT_EN]; // [R15]
	assign thermalAutoRecoverEn = miscCtrlReg[prot_fault_pkg::THERMAL_AUTO_RECOVER_EN]; // [R14]
	assign analogFaultClear     = clearPulseReg;

	// Warning bank; cycle-limit warnings only count while the limiter and its warning run
	always_comb begin
		warnIf.cond = '0;
		warnIf.cond[prot_fault_pkg::OVERTEMP_WARN_LEVEL_FOUR:0] = overtempWarnCond; // [R2] [R3]
		warnIf.cond[prot_fault_pkg::LEFT_CYCLE_LIMIT_WARN] =
			leftCycleLimitWarnCond & cycleLimitEn & cycleLimitWarnEn; // [R1]
		warnIf.cond[prot_fault_pkg::RIGHT_CYCLE_LIMIT_WARN] =
			rightCycleLimitWarnCond & cycleLimitEn & cycleLimitWarnEn; // [R1]
	end

	always_comb begin
		warnIf.latchEn = '0;
		warnIf.latchEn[prot_fault_pkg::OVERTEMP_WARN_LEVEL_FOUR:0] =
			{4{latchMaskReg[prot_fault_pkg::OVERTEMP_WARN_LATCH_EN]}}; // [R11]
		warnIf.latchEn[prot_fault_pkg::LEFT_CYCLE_LIMIT_WARN] =
			latchMaskReg[prot_fault_pkg::CYCLE_LIMIT_WARN_LATCH_EN]; // [R10]
		warnIf.latchEn[prot_fault_pkg::RIGHT_CYCLE_LIMIT_WARN] =
			latchMaskReg[prot_fault_pkg::CYCLE_LIMIT_WARN_LATCH_EN]; // [R10]
	end

	assign warnIf.clear = clearPulseReg; // [R16]

	// Fault bank
	always_comb begin
		faultIf.cond = '0;
		faultIf.cond[prot_fault_pkg::FLT_OC_LEFT]      = leftOvercurrentCond; // [R17]
		faultIf.cond[prot_fault_pkg::FLT_OC_RIGHT]     = rightOvercurrentCond;
		faultIf.cond[prot_fault_pkg::FLT_DC_LEFT]      = leftOutputOffsetCond;
		faultIf.cond[prot_fault_pkg::FLT_DC_RIGHT]     = rightOutputOffsetCond;
		faultIf.cond[prot_fault_pkg::FLT_PWR_UNDER]    = powerSupplyUnderCond;
		faultIf.cond[prot_fault_pkg::FLT_PWR_OVER]     = powerSupplyOverCond;
		faultIf.cond[prot_fault_pkg::FLT_CLOCK]        = clockErrorCond;
		faultIf.cond[prot_fault_pkg::FLT_CYCLE_LEFT]   =
			leftCycleLimitFaultCond & cycleLimitEn & cycleLimitFaultEn; // [R15]
		faultIf.cond[prot_fault_pkg::FLT_CYCLE_RIGHT]  =
			rightCycleLimitFaultCond & cycleLimitEn & cycleLimitFaultEn; // [R15]
		faultIf.cond[prot_fault_pkg::FLT_THERMAL]      = thermalShutdownCond;
		faultIf.cond[prot_fault_pkg::FLT_CLOCK_DETECT] = clockDetectCond;
	end

	// Analog faults always stick until cleared; the others follow their enables
	always_comb begin
		faultIf.latchEn = '1;
		faultIf.latchEn[prot_fault_pkg::FLT_CLOCK] =
			latchMaskReg[prot_fault_pkg::CLOCK_ERROR_LATCH_EN]; // [R10]
		faultIf.latchEn[prot_fault_pkg::FLT_CYCLE_LEFT] =
			latchMaskReg[prot_fault_pkg::CYCLE_LIMIT_FAULT_LATCH_EN]; // [R10]
		faultIf.latchEn[prot_fault_pkg::FLT_CYCLE_RIGHT] =
			latchMaskReg[prot_fault_pkg::CYCLE_LIMIT_FAULT_LATCH_EN]; // [R10]
		faultIf.latchEn[prot_fault_pkg::FLT_THERMAL] =
			latchMaskReg[prot_fault_pkg::THERMAL_SHUTDOWN_LATCH_EN]; // [R11]
		faultIf.latchEn[prot_fault_pkg::FLT_CLOCK_DETECT] =
			miscCtrlReg[prot_fault_pkg::CLOCK_DETECT_HOLD]; // [R13]
	end

	assign faultIf.clear = clearPulseReg; // [R16]

	flag_latch_bank warnBank (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.fb      (warnIf.bank)
	);

	flag_latch_bank faultBank (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.fb      (faultIf.bank)
	);

	assign warningFlagsReg   = {2'h0, warnIf.flags}; // [R1] [R4]
	assign faultStatus       = faultIf.flags; // [R19]
	assign clockDetectStatus = faultIf.flags[prot_fault_pkg::FLT_CLOCK_DETECT]; // [R13]

	fault_report_unit reportUnit (
		.ref_clk              (ref_clk),
		.nrst                 (nrst),
		.faultFlags           (faultIf.flags),
		.warnFlags            (warnIf.flags),
		.faultMaskReg         (faultMaskReg),
		.latchMaskReg         (latchMaskReg),
		.thermalAutoRecoverEn (thermalAutoRecoverEn),
		.thermalShutdownCond  (thermalShutdownCond),
		.powerSupplyUnderCond (powerSupplyUnderCond),
		.powerSupplyOverCond  (powerSupplyOverCond),
		.clockErrorCond       (clockErrorCond),
		.logicSupplyUnderCond (logicSupplyUnderCond),
		.logicSupplyOverCond  (logicSupplyOverCond),
		.faultPinN            (faultPinN),
		.outputHiZ            (outputHiZ)
	);

	// Read mux; unmapped offsets read zero
	always_comb begin
		unique case (regAddr)
			prot_fault_pkg::ADDR_WARNING_FLAGS: regRdData_next = warningFlagsReg; // [R4]
			prot_fault_pkg::ADDR_FAULT_MASK:    regRdData_next = faultMaskReg;
			prot_fault_pkg::ADDR_LATCH_MASK:    regRdData_next = latchMaskReg;
			prot_fault_pkg::ADDR_MISC_CTRL:     regRdData_next = miscCtrlReg;
			prot_fault_pkg::ADDR_CURRENT_LIMIT: regRdData_next = currentLimitReg;
			prot_fault_pkg::ADDR_FAULT_CLEAR:   regRdData_next = faultClearReg;
			default:                            regRdData_next = 8'h00;
		endcase
	end

	// Read data is captured on the strobe and held until the next read
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= regRdData_next;
		end
	end

endmodule : protection_fault_report_ctrl

// ### dv/prot_fault_props.sv
// Checker for the protection reporting register bank, bound to its top ports.
// Assumes one ref_clk domain and an asynchronous active-low nrst.
`timescale 1ns/1ps
module prot_fault_props (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        regWrEn,
	input wire logic        regRdEn,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWrData,
	input wire logic [7:0]  regRdData,
	input wire logic        leftOvercurrentCond,
	input wire logic        powerSupplyUnderCond,
	input wire logic [10:0] faultStatus,
	input wire logic        cycleLimitEn,
	input wire logic        cycleLimitWarnEn,
	input wire logic        cycleLimitFaultEn,
	input wire logic        thermalAutoRecoverEn,
	input wire logic        analogFaultClear,
	input wire logic        faultPinN,
	input wire logic        outputHiZ
);
	logic [7:0] maskShadow_reg;
	logic [7:0] wrData_reg;
	// Shadow of the pin mask so pin checks know what is hidden
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			maskShadow_reg <= 8'h00;
		else if (regWrEn && regAddr == 8'h74)
			maskShadow_reg <= regWrData;
	end
	always_ff @(posedge ref_clk) begin
		wrData_reg <= regWrData;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_clear_pulse;
		regWrEn && regAddr == 8'h78 && regWrData[7] |=> analogFaultClear ##1 !analogFaultClear;
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse wrong");
	property p_limit_ctrl;
		regWrEn && regAddr == 8'h77
			|=> {cycleLimitEn, cycleLimitWarnEn, cycleLimitFaultEn} == wrData_reg[2:0];
	endproperty
	a_limit_ctrl: assert property (p_limit_ctrl) else $error("limit enables wrong");
	property p_auto_rec;
		regWrEn && regAddr == 8'h76 |=> thermalAutoRecoverEn == wrData_reg[4];
	endproperty
	a_auto_rec: assert property (p_auto_rec) else $error("auto recover wrong");
	property p_warn_top;
		regRdEn && regAddr == 8'h73 |=> regRdData[7:6] == 2'h0;
	endproperty
	a_warn_top: assert property (p_warn_top) else $error("warning top bits set");
	property p_mask_rsv;
		regRdEn && regAddr == 8'h74 |=> !regRdData[3];
	endproperty
	a_mask_rsv: assert property (p_mask_rsv) else $error("reserved mask bit set");
	property p_oc_stick;
		faultStatus[0] && !analogFaultClear |=> faultStatus[0];
	endproperty
	a_oc_stick: assert property (p_oc_stick) else $error("fault flag lost");
	property p_oc_set;
		leftOvercurrentCond |-> ##1 faultStatus[0] ##1 outputHiZ;
	endproperty
	a_oc_set: assert property (p_oc_set) else $error("overcurrent not handled");
	property p_pwr_flag;
		powerSupplyUnderCond |=> faultStatus[4] && outputHiZ;
	endproperty
	a_pwr_flag: assert property (p_pwr_flag) else $error("supply fault not handled");
	property p_pin_oc;
		faultStatus[0] && !maskShadow_reg[0] |=> !faultPinN;
	endproperty
	a_pin_oc: assert property (p_pin_oc) else $error("fault pin not driven");
endmodule : prot_fault_props
bind protection_fault_report_ctrl prot_fault_props chk_u (.ref_clk, .nrst, .regWrEn,
	.regRdEn, .regAddr, .regWrData, .regRdData, .leftOvercurrentCond, .powerSupplyUnderCond,
	.faultStatus, .cycleLimitEn, .cycleLimitWarnEn, .cycleLimitFaultEn,
	.thermalAutoRecoverEn, .analogFaultClear, .faultPinN, .outputHiZ);

// ### dv/reg_host.sv
// Host model: register master issuing single-byte strobe accesses.
// Assumes strobes are sampled on the rising edge of ref_clk.
`timescale 1ns/1ps
module reg_host (
	input wire logic       ref_clk,
	output logic           regWrEn,
	output logic           regRdEn,
	output logic [7:0]     regAddr,
	output logic [7:0]     regWrData,
	input wire logic [7:0] regRdData
);
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(posedge ref_clk);
		#1;
		regWrEn = 1'b0;
		// Released lines must not keep showing the old value
		regAddr = ~a;
		regWrData = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1;
		regRdEn = 1'b1;
		regAddr = a;
		@(posedge ref_clk);
		#1;
		regRdEn = 1'b0;
		regAddr = ~a;
		d = regRdData;
	endtask : rd
endmodule : reg_host

// ### dv/protection_fault_report_ctrl_tb.sv
// Self-checking bench for the protection reporting register bank.
// Assumes reg_host as register master; detector levels are driven here.
`timescale 1ns/1ps
module protection_fault_report_ctrl_tb;
	logic        ref_clk;
	logic        nrst;
	logic        regWrEn;
	logic        regRdEn;
	logic [7:0]  regAddr;
	logic [7:0]  regWrData;
	logic [7:0]  regRdData;
	logic [18:0] cv;
	logic [10:0] faultStatus;
	logic        clockDetectStatus;
	logic        cycleLimitEn;
	logic        cycleLimitWarnEn;
	logic        cycleLimitFaultEn;
	logic        thermalAutoRecoverEn;
	logic        analogFaultClear;
	logic        faultPinN;
	logic        outputHiZ;
	logic [7:0]  d;
	int          n_errors;
	int          total_checks;
	int          cycles;
	protection_fault_report_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.leftCycleLimitWarnCond(cv[0]), .rightCycleLimitWarnCond(cv[1]),
		.overtempWarnCond(cv[5:2]), .leftCycleLimitFaultCond(cv[6]),
		.rightCycleLimitFaultCond(cv[7]), .leftOvercurrentCond(cv[8]),
		.rightOvercurrentCond(cv[9]), .leftOutputOffsetCond(cv[10]),
		.rightOutputOffsetCond(cv[11]), .powerSupplyUnderCond(cv[12]),
		.powerSupplyOverCond(cv[13]), .logicSupplyUnderCond(cv[14]),
		.logicSupplyOverCond(cv[15]), .clockErrorCond(cv[16]), .clockDetectCond(cv[17]),
		.thermalShutdownCond(cv[18]), .faultStatus(faultStatus),
		.clockDetectStatus(clockDetectStatus), .cycleLimitEn(cycleLimitEn),
		.cycleLimitWarnEn(cycleLimitWarnEn), .cycleLimitFaultEn(cycleLimitFaultEn),
		.thermalAutoRecoverEn(thermalAutoRecoverEn), .analogFaultClear(analogFaultClear),
		.faultPinN(faultPinN), .outputHiZ(outputHiZ));
	reg_host host_u (.ref_clk(ref_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	// Whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic t_reset;
		logic [7:0] ad [6] = '{8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h50};
		logic [7:0] rv [6] = '{8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			host_u.rd(ad[i], d);
			chk("reset value", d, rv[i]);
		end
		$display("reset values done");
	endtask : t_reset
	task automatic t_access;
		host_u.wr(8'h73, 8'hff);
		host_u.rd(8'h73, d);
		chk("warning write", d, 8'h00);
		host_u.wr(8'h74, 8'hff);
		host_u.rd(8'h74, d);
		chk("mask readback", d, 8'hf7);
		host_u.wr(8'h50, 8'hff);
		host_u.rd(8'h50, d);
		chk("unmapped read", d, 8'h00);
		host_u.wr(8'h76, 8'h90);
		host_u.rd(8'h76, d);
		chk("misc readback", d, 8'h90);
		chk("auto recover", thermalAutoRecoverEn, 1'b1);
		host_u.wr(8'h77, 8'h05);
		chk("limit enables", {cycleLimitEn, cycleLimitWarnEn, cycleLimitFaultEn}, 3'h5);
		host_u.wr(8'h77, 8'h02);
		chk("limit enables", {cycleLimitEn, cycleLimitWarnEn, cycleLimitFaultEn}, 3'h2);
		host_u.wr(8'h74, 8'h00);
		host_u.wr(8'h76, 8'h00);
		$display("access test done");
	endtask : t_access
	task automatic t_warn;
		int k;
		host_u.wr(8'h75, 8'h00);
		host_u.wr(8'h77, 8'h07);
		for (int i = 0; i < 6; i++) begin
			k = (i < 4) ? 2 + i : 5 - i;
			cv[k] = 1'b1;
			cyc(2);
			host_u.rd(8'h73, d);
			chk("warning bit", d, 11'h1 << i);
			cv[k] = 1'b0;
			cyc(2);
			host_u.rd(8'h73, d);
			chk("unlatched warning", d, 8'h00);
		end
		host_u.wr(8'h75, 8'h08);
		cv[2] = 1'b1;
		cyc(1);
		cv[2] = 1'b0;
		cyc(3);
		host_u.rd(8'h73, d);
		chk("latched warning", d, 8'h01);
		host_u.wr(8'h78, 8'h80);
		chk("clear pulse", analogFaultClear, 1'b1);
		cyc(2);
		host_u.rd(8'h73, d);
		chk("warning cleared", d, 8'h00);
		host_u.rd(8'h78, d);
		chk("clear bit unstored", d, 8'h00);
		host_u.wr(8'h75, 8'hf8);
		$display("warning test done");
	endtask : t_warn
	task automatic t_mask;
		int         ix [10] = '{18, 14, 15, 16, 12, 10, 8, 2, 0, 6};
		int         fb [10] = '{9, 11, 11, 6, 4, 2, 0, 11, 11, 7};
		logic [7:0] ad [10] = '{8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74,
			8'h75, 8'h75, 8'h75};
		logic [7:0] mv [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01,
			8'hfc, 8'hfa, 8'hf9};
		for (int i = 0; i < 10; i++) begin
			host_u.wr(ad[i], mv[i]);
			cv[ix[i]] = 1'b1;
			cyc(3);
			chk("pin while masked", faultPinN, 1'b1);
			chk("flag while masked", faultStatus, 11'h1 << fb[i]);
			host_u.wr(ad[i], (i < 7) ? 8'h00 : 8'hf8);
			cyc(2);
			chk("pin unmasked", faultPinN, 1'b0);
			cv[ix[i]] = 1'b0;
			host_u.wr(8'h78, 8'h80);
			cyc(3);
			chk("pin after clear", faultPinN, 1'b1);
		end
		$display("mask test done");
	endtask : t_mask
	task automatic t_autorec;
		host_u.wr(8'h76, 8'h10);
		cv[18] = 1'b1;
		cyc(2);
		chk("stage off", outputHiZ, 1'b1);
		cv[18] = 1'b0;
		cyc(2);
		chk("auto recovered", outputHiZ, 1'b0);
		chk("thermal flag held", faultStatus[9], 1'b1);
		host_u.wr(8'h76, 8'h00);
		cyc(2);
		chk("no auto recovery", outputHiZ, 1'b1);
		host_u.wr(8'h78, 8'h80);
		cyc(3);
		chk("stage on after clear", outputHiZ, 1'b0);
		$display("recovery test done");
	endtask : t_autorec
	task automatic t_clkdet;
		cv[17] = 1'b1;
		cyc(1);
		cv[17] = 1'b0;
		cyc(2);
		chk("detect unlatched", clockDetectStatus, 1'b0);
		host_u.wr(8'h76, 8'h80);
		cv[17] = 1'b1;
		cyc(1);
		cv[17] = 1'b0;
		cyc(2);
		chk("detect latched", clockDetectStatus, 1'b1);
		host_u.wr(8'h78, 8'h80);
		cyc(3);
		chk("detect cleared", clockDetectStatus, 1'b0);
		$display("clock detect test done");
	endtask : t_clkdet
	initial begin
		nrst = 1'b0;
		cv = '0;
		n_errors = 0;
		total_checks = 0;
		cycles = 0;
		repeat (4) @(posedge ref_clk);
		#1;
		nrst = 1'b1;
		t_reset();
		t_access();
		t_warn();
		t_mask();
		t_autorec();
		t_clkdet();
		final_report();
	end
endmodule : protection_fault_report_ctrl_tb
